// *** hw/rmis_chan.sv ***
// one input channel: seven-bit source selector and output flop
`timescale 1ns/1ps
`include "rmis_consts.svh"
module rmis_chan (
  input  wire logic                       ref_clk,
  input  wire logic                       sys_rst,
  input  wire logic [`RMIS_SEL_W-1:0]     sel,
  input  wire logic [`RMIS_PIN_W-1:0]     src_vec,
  output logic                            chan_out
);
  logic nxt_out;
  // pick the source whose code equals the selection; vector holds zero on unused codes
  always_comb begin
    nxt_out = src_vec[sel];
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      chan_out <= 1'b0;
    end else begin
      chan_out <= nxt_out;
    end
  end
endmodule // rmis_chan

// *** hw/rmis_consts.svh ***
// constants for the remappable input select block
`ifndef RMIS_CONSTS_SVH
`define RMIS_CONSTS_SVH
`define RMIS_SEL_W        7
`define RMIS_NUM_IN       24
`define RMIS_SEL_GND      7'h00
`define RMIS_SEL_CMP1     7'h01
`define RMIS_SEL_CMP4     7'h04
`define RMIS_SEL_TRIG30   7'h06
`define RMIS_SEL_TRIG31   7'h07
`define RMIS_SEL_FINDX    7'h08
`define RMIS_SEL_FHOME    7'h09
`define RMIS_PIN_W        128
`define RMIS_UNLOCK_KEY1  16'h0055
`define RMIS_UNLOCK_KEY2  16'h00aa
`define RMIS_SEL_RST      7'h00
`define RMIS_PWM_FAULT_IN_1_IDX     8
`endif

// *** hw/rmis_pkg.sv ***
// types for the remappable input select block
package rmis_pkg;
  typedef logic [6:0] rmis_sel_t;
  typedef enum logic [1:0] {
    RMIS_LOCKED  = 2'b00,
    RMIS_KEY1OK  = 2'b01,
    RMIS_OPEN    = 2'b10
  } rmis_lock_e;
endpackage

// *** hw/rmis_top.sv ***
// remappable input select crossbar top
//
// How it works
// [R1] inputs have no default pin; a pin reaches one only when selected
// [R2] a remapped input takes the pin ahead of port and fixed peripheral use
// [R3] pins set analog never feed a remapped digital input
// [R4] only input mapping here; output mapping is a separate register set
// [R5] each peripheral input owns one seven-bit selection field
// [R6] a pin code routes the remappable pin with that same number
// [R7] software writes only codes the device supports
// [R8] only a fixed subset of pins, bidirectional or input-only, is selectable
// [R9] protection keeps an established mapping from spurious writes
// [R10] codes 1 to 4 pick comparators, 6 and 7 trigger outputs 30 and 31
// [R11] codes 8 and 9 pick filtered encoder index and home
// [R12] software enables the encoder filter and maps its input to a pin
// [R13] code 1 on the first fault input connects comparator 1
// [R14] twenty-four peripheral inputs, each with a field of its own
// [R15] two-wire serial, pwm outputs and analog modules are not selectable
// [R16] remapping limited to a fixed set of digital pins
// [R17] zero ties the input low; every field resets to zero
// [R18] no interlock between fields; one pin may feed many inputs
// [R19] unassigned or out of range codes give constant low
// [R20] a lock flag blocks field writes until a two-key unlock sequence
//
// channel order: 0 ext_irq_1, 1 ext_irq_2, 2 timer2_ext_clk, 3-6 capture_in_1..4,
// 7 compare_fault_a, 8 pwm_fault_in_1, 9 pwm_fault_in_2, 10 encoder_phase_a,
// 11 encoder_phase_b, 12 encoder_index, 13 encoder_home, 14 uart1_receive_in,
// 15 uart2_receive_in, 16 spi2 data in, 17 spi2 clock in, 18 spi2 select in,
// 19 can_receive_in, 20 pwm_sync_in, 21-23 deadtime_comp_in_1..3
`timescale 1ns/1ps
`include "rmis_consts.svh"
module rmis_top #(
  parameter int NUM_IN = `RMIS_NUM_IN
) (
  input  wire logic                              ref_clk,
  input  wire logic                              sys_rst,
  input  wire logic [`RMIS_PIN_W-1:0]            pin_in,
  input  wire logic [`RMIS_PIN_W-1:0]            pin_analog,
  input  wire logic [3:0]                        comparator_out,
  input  wire logic                              trig_gen_out30,
  input  wire logic                              trig_gen_out31,
  input  wire logic                              filtered_index_1,
  input  wire logic                              filtered_home_1,
  input  wire logic                              sel_wr,
  input  wire logic [4:0]                        sel_idx,
  input  wire logic [`RMIS_SEL_W-1:0]            sel_wdata,
  input  wire logic                              key_wr,
  input  wire logic [15:0]                       key_data,
  input  wire logic                              lock_set,
  output logic [NUM_IN-1:0]                      periph_in,
  output logic [NUM_IN*`RMIS_SEL_W-1:0]          sel_fields,
  output logic [`RMIS_PIN_W-1:0]                 pin_claimed,
  output logic                                   map_locked,
  output logic                                   wr_refused
);
  // pins that exist as remappable inputs; bidir ones also take output mapping
  // implemented: 20, 24, 25, 27, 28, 32-47, 51-58, 94-97
  localparam logic [`RMIS_PIN_W-1:0] PIN_IMPL  = 128'h0000_0003_c000_0000_07f8_ffff_1b10_0000;
  // bidirectional: 20, 35-43, 54-57, 97
  localparam logic [`RMIS_PIN_W-1:0] PIN_BIDIR = 128'h0000_0002_0000_0000_03c0_0ff8_0010_0000;
  // the five-bit field index cannot address more than 32 inputs
  if (NUM_IN < 1 || NUM_IN > 32) begin : g_bad_num_in
    $error("rmis_top: NUM_IN out of range");
  end

  // pin sampling through two flops [R8]
  logic [`RMIS_PIN_W-1:0] pin_s1_ff, pin_s2_ff, nxt_s1, nxt_s2;
  logic [3:0] virt_s1_ff, virt_s2_ff;
  logic [1:0] trg_s1_ff, trg_s2_ff;
  logic [1:0] qf_s1_ff, qf_s2_ff;
  always_comb begin
    nxt_s1 = pin_in;
    nxt_s2 = pin_s1_ff;
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_s1_ff  <= '0;
      pin_s2_ff  <= '0;
      virt_s1_ff <= '0;
      virt_s2_ff <= '0;
      trg_s1_ff  <= '0;
      trg_s2_ff  <= '0;
      qf_s1_ff   <= '0;
      qf_s2_ff   <= '0;
    end else begin
      pin_s1_ff  <= nxt_s1;
      pin_s2_ff  <= nxt_s2;
      virt_s1_ff <= comparator_out;
      virt_s2_ff <= virt_s1_ff;
      trg_s1_ff  <= {trig_gen_out31, trig_gen_out30};
      trg_s2_ff  <= trg_s1_ff;
      qf_s1_ff   <= {filtered_home_1, filtered_index_1};
      qf_s2_ff   <= qf_s1_ff;
    end
  end

  // analog setting also synchronised; analog pins read low to digital [R3]
  logic [`RMIS_PIN_W-1:0] ana_s1_ff, ana_s2_ff;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ana_s1_ff <= '0;
      ana_s2_ff <= '0;
    end else begin
      ana_s1_ff <= pin_analog;
      ana_s2_ff <= ana_s1_ff;
    end
  end

  // source vector indexed by code; unlisted codes stay zero [R17] [R19]
  logic [`RMIS_PIN_W-1:0] src_vec;
  always_comb begin
    src_vec = pin_s2_ff & PIN_IMPL & ~ana_s2_ff; // [R6] [R8] [R16] [R3]
    src_vec[`RMIS_SEL_GND] = 1'b0; // [R17]
    src_vec[`RMIS_SEL_CMP4:`RMIS_SEL_CMP1] = virt_s2_ff; // [R10] [R13]
    src_vec[5] = 1'b0; // [R19]
    src_vec[`RMIS_SEL_TRIG30] = trg_s2_ff[0]; // [R10]
    src_vec[`RMIS_SEL_TRIG31] = trg_s2_ff[1];
    src_vec[`RMIS_SEL_FINDX] = qf_s2_ff[0]; // [R11]
    src_vec[`RMIS_SEL_FHOME] = qf_s2_ff[1];
  end

  // lock state: unlock needs key1 then key2; lock_set or a selection write between the keys relocks [R9] [R20]
  rmis_pkg::rmis_lock_e lock_ff, nxt_lock;
  always_comb begin
    nxt_lock = lock_ff;
    unique case (lock_ff)
      rmis_pkg::RMIS_LOCKED: begin
        if (key_wr && key_data == `RMIS_UNLOCK_KEY1) nxt_lock = rmis_pkg::RMIS_KEY1OK;
      end
      rmis_pkg::RMIS_KEY1OK: begin
        if (key_wr) begin
          nxt_lock = (key_data == `RMIS_UNLOCK_KEY2) ? rmis_pkg::RMIS_OPEN : rmis_pkg::RMIS_LOCKED;
        end else if (sel_wr) begin
          nxt_lock = rmis_pkg::RMIS_LOCKED;
        end
      end
      rmis_pkg::RMIS_OPEN: begin
        if (lock_set) nxt_lock = rmis_pkg::RMIS_LOCKED;
      end
      default: nxt_lock = rmis_pkg::RMIS_LOCKED;
    endcase
    if (lock_set) nxt_lock = rmis_pkg::RMIS_LOCKED;
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      lock_ff <= rmis_pkg::RMIS_OPEN;
    end else begin
      lock_ff <= nxt_lock;
    end
  end

  // selection field storage, one field per input, reset to ground [R5] [R14] [R17] [R4]
  rmis_pkg::rmis_sel_t sel_ff [NUM_IN];
  rmis_pkg::rmis_sel_t nxt_sel [NUM_IN];
  logic                nxt_refused;
  logic                wr_ok;
  always_comb begin
    wr_ok = sel_wr && (lock_ff == rmis_pkg::RMIS_OPEN) && (32'(sel_idx) < NUM_IN); // [R20]
    nxt_refused = sel_wr && !wr_ok;
    for (int i = 0; i < NUM_IN; i++) begin
      nxt_sel[i] = sel_ff[i];
      if (wr_ok && 32'(sel_idx) == i) nxt_sel[i] = sel_wdata; // [R18]
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_IN; i++) sel_ff[i] <= `RMIS_SEL_RST; // [R1] [R17]
      wr_refused <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_IN; i++) sel_ff[i] <= nxt_sel[i];
      wr_refused <= nxt_refused;
    end
  end

  // status outputs: fields, lock, pins claimed by remapped inputs [R2]
  logic [NUM_IN*`RMIS_SEL_W-1:0] nxt_fields;
  logic [`RMIS_PIN_W-1:0]        nxt_claim;
  always_comb begin
    nxt_claim = '0;
    for (int i = 0; i < NUM_IN; i++) begin
      nxt_fields[i*`RMIS_SEL_W +: `RMIS_SEL_W] = sel_ff[i];
      if (PIN_IMPL[sel_ff[i]] && !ana_s2_ff[sel_ff[i]]) nxt_claim[sel_ff[i]] = 1'b1; // [R2] [R3]
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sel_fields  <= '0;
      pin_claimed <= '0;
      map_locked  <= 1'b0;
    end else begin
      sel_fields  <= nxt_fields;
      pin_claimed <= nxt_claim;
      map_locked  <= (nxt_lock != rmis_pkg::RMIS_OPEN);
    end
  end

  // one selector channel per peripheral input [R14] [R15]
  for (genvar g = 0; g < NUM_IN; g++) begin : g_chan
    rmis_chan u_chan (
      .ref_clk  (ref_clk),
      .sys_rst  (sys_rst),
      .sel      (sel_ff[g]),
      .src_vec  (src_vec),
      .chan_out (periph_in[g])
    );
  end
  // bidir mask kept for the output-mapping side; unused here [R4]
  logic unused_bidir;
  assign unused_bidir = ^PIN_BIDIR;
endmodule // rmis_top

// *** sim/rmis_properties.sv ***
// checker for the remappable input select top
`timescale 1ns/1ps
`include "rmis_consts.svh"
module rmis_checker #(
  parameter int NUM_IN = `RMIS_NUM_IN
) (
  input wire logic                          ref_clk,
  input wire logic                          sys_rst,
  input wire logic [`RMIS_PIN_W-1:0]        pin_in,
  input wire logic [`RMIS_PIN_W-1:0]        pin_analog,
  input wire logic [3:0]                    comparator_out,
  input wire logic                          sel_wr,
  input wire logic [4:0]                    sel_idx,
  input wire logic [`RMIS_SEL_W-1:0]        sel_wdata,
  input wire logic                          key_wr,
  input wire logic [15:0]                   key_data,
  input wire logic                          lock_set,
  input wire logic [NUM_IN-1:0]             periph_in,
  input wire logic [NUM_IN*`RMIS_SEL_W-1:0] sel_fields,
  input wire logic [`RMIS_PIN_W-1:0]        pin_claimed,
  input wire logic                          map_locked,
  input wire logic                          wr_refused
);
  // one clock domain, reset disables all checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  rst_clear_a: assert property ($fell(sys_rst) |-> sel_fields == '0 && periph_in == '0 && !map_locked)
    else $error("outputs not clear after reset");
  ground_low_a: assert property ((sel_fields[13:7] == 7'h00)[*3] |-> !periph_in[1])
    else $error("ground selection not low");
  pin_route_a: assert property (($stable(pin_in[20]) && !pin_analog[20] && sel_fields[6:0] == 7'h14)[*4]
    |-> periph_in[0] == pin_in[20]) else $error("pin not routed");
  cmp_route_a: assert property (($stable(comparator_out[0]) && sel_fields[62:56] == 7'h01)[*4]
    |-> periph_in[8] == comparator_out[0]) else $error("comparator not routed");
  analog_wins_a: assert property ($stable(pin_analog)[*4] |-> (pin_claimed & pin_analog) == '0)
    else $error("analog pin claimed");
  bad_idx_a: assert property (sel_wr && sel_idx >= NUM_IN |=> wr_refused)
    else $error("bad index not refused");
  lock_refuse_a: assert property (sel_wr && map_locked && !key_wr && !lock_set |=> wr_refused)
    else $error("locked write not refused");
  field_write_a: assert property (sel_wr && !map_locked && sel_idx < NUM_IN && !key_wr && !lock_set
    |=> !wr_refused ##1 sel_fields[7*$past(sel_idx, 2)+:7] == $past(sel_wdata, 2)) else $error("field not written");
  lock_take_a: assert property (lock_set |-> ##[1:2] map_locked)
    else $error("lock not taken");
  unlock_seq_a: assert property (map_locked && key_wr && key_data == 16'h0055 && !sel_wr && !lock_set
    ##1 key_wr && key_data == 16'h00aa && !sel_wr && !lock_set |-> ##[1:2] !map_locked) else $error("no unlock");
  // main scenarios reached
  cover property (sel_wr && map_locked ##1 wr_refused);
  cover property (sel_fields[62:56] == 7'h01 && periph_in[8]);
  cover property (lock_set ##2 map_locked);
endmodule // rmis_checker

bind rmis_top rmis_checker #(.NUM_IN(NUM_IN)) u_chk (.ref_clk, .sys_rst, .pin_in, .pin_analog, .comparator_out,
  .sel_wr, .sel_idx, .sel_wdata, .key_wr, .key_data, .lock_set, .periph_in, .sel_fields, .pin_claimed,
  .map_locked, .wr_refused);

// *** sim/rmis_src_model.sv ***
// model of the pins and internal sources feeding the block
`timescale 1ns/1ps
`include "rmis_consts.svh"
module rmis_src_model (
  input  wire logic                   lvl,
  input  wire logic [6:0]             pin_no,
  input  wire logic                   ana,
  output logic [`RMIS_PIN_W-1:0]      pin_in,
  output logic [`RMIS_PIN_W-1:0]      pin_analog,
  output logic [3:0]                  comparator_out,
  output logic                        trig_gen_out30,
  output logic                        trig_gen_out31,
  output logic                        filtered_index_1,
  output logic                        filtered_home_1
);
  // chosen pin shows lvl, every other pin its inverse, so a wrong route shows
  always_comb begin
    pin_in = {`RMIS_PIN_W{~lvl}};
    pin_in[pin_no] = lvl;
    pin_analog = '0;
    pin_analog[pin_no] = ana;
    comparator_out = {~lvl, lvl, ~lvl, lvl};
    trig_gen_out30 = lvl;
    trig_gen_out31 = ~lvl;
    filtered_index_1 = lvl;
    filtered_home_1 = ~lvl;
  end
endmodule // rmis_src_model

// *** sim/testbench.sv ***
// self-checking bench for the remappable input select block
`timescale 1ns/1ps
`include "rmis_consts.svh"
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module testbench;
  localparam logic [127:0] IMPL = 128'h0000_0003_c000_0000_07f8_ffff_1b10_0000;
  logic ref_clk = 1'b0, sys_rst = 1'b1, sel_wr = 1'b0, key_wr = 1'b0, lock_set = 1'b0, lvl = 1'b0, ana = 1'b0, rf;
  logic [4:0]   sel_idx = 5'h00;
  logic [6:0]   sel_wdata = 7'h00, pin_no = 7'h14;
  logic [15:0]  key_data = 16'h0000;
  logic [127:0] pin_in, pin_analog, pin_claimed;
  logic [3:0]   comparator_out;
  logic [23:0]  periph_in;
  logic [167:0] sel_fields;
  logic         trig_gen_out30, trig_gen_out31, filtered_index_1, filtered_home_1, map_locked, wr_refused;
  logic [6:0]   cl[17] = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h07, 7'h08, 7'h09, 7'h0a, 7'h14, 7'h15,
                           7'h18, 7'h30, 7'h61, 7'h62, 7'h7f};
  int mismatches = 0, n_compared = 0;
  rmis_top i_dut (.ref_clk, .sys_rst, .pin_in, .pin_analog, .comparator_out, .trig_gen_out30, .trig_gen_out31,
    .filtered_index_1, .filtered_home_1, .sel_wr, .sel_idx, .sel_wdata, .key_wr, .key_data, .lock_set,
    .periph_in, .sel_fields, .pin_claimed, .map_locked, .wr_refused);
  rmis_src_model i_src (.lvl, .pin_no, .ana, .pin_in, .pin_analog, .comparator_out, .trig_gen_out30,
    .trig_gen_out31, .filtered_index_1, .filtered_home_1);
  always #2.5 ref_clk = ~ref_clk;
  // expected source level for a code with no analog pin set
  function automatic logic expv(input logic [6:0] c);
    if (c inside {7'h01, 7'h03, 7'h06, 7'h08}) return lvl;
    if (c inside {7'h02, 7'h04, 7'h07, 7'h09}) return ~lvl;
    if (IMPL[c]) return (c == pin_no) ? lvl : ~lvl;
    return 1'b0;
  endfunction
  // one field write, refusal sampled after its edge
  task automatic wr(input logic [4:0] i, input logic [6:0] d);
    @(negedge ref_clk);
    sel_wr = 1'b1;
    sel_idx = i;
    sel_wdata = d;
    @(negedge ref_clk);
    sel_wr = 1'b0;
    rf = wr_refused;
  endtask
  // two-key unlock, optionally broken by a write between keys
  task automatic keys(input logic brk);
    @(negedge ref_clk);
    key_wr = 1'b1;
    key_data = 16'h0055;
    @(negedge ref_clk);
    if (brk) begin
      key_wr = 1'b0;
      sel_wr = 1'b1;
      @(negedge ref_clk);
      sel_wr = 1'b0;
      key_wr = 1'b1;
    end
    key_data = 16'h00aa;
    @(negedge ref_clk);
    key_wr = 1'b0;
    repeat (3) @(negedge ref_clk);
  endtask
  // every listed code on the first fault input, both levels
  task automatic t_codes();
    foreach (cl[k]) begin
      wr(5'h08, cl[k]);
      for (int v = 0; v < 2; v++) begin
        lvl = v[0];
        repeat (4) @(negedge ref_clk);
        `CHK("fault1 source", expv(cl[k]), periph_in[`RMIS_PWM_FAULT_IN_1_IDX])
      end
      `CHK("fault1 field", cl[k], sel_fields[62:56])
    end
    $display("codes test done");
  endtask
  // one pin to two inputs, then analog, then ground
  task automatic t_fan();
    wr(5'h00, 7'h14);
    wr(5'h17, 7'h14);
    repeat (4) @(negedge ref_clk);
    `CHK("first input", 1'b1, periph_in[0])
    `CHK("last input", 1'b1, periph_in[23])
    `CHK("pin claim", 1'b1, pin_claimed[20])
    ana = 1'b1;
    repeat (5) @(negedge ref_clk);
    `CHK("analog input", 1'b0, periph_in[0])
    `CHK("analog claim", 1'b0, pin_claimed[20])
    ana = 1'b0;
    wr(5'h00, 7'h00);
    repeat (4) @(negedge ref_clk);
    `CHK("ground input", 1'b0, periph_in[0])
    $display("fan test done");
  endtask
  // lock, refused write, broken and good unlock, bad index
  task automatic t_lock();
    @(negedge ref_clk);
    lock_set = 1'b1;
    @(negedge ref_clk);
    lock_set = 1'b0;
    repeat (2) @(negedge ref_clk);
    `CHK("locked", 1'b1, map_locked)
    wr(5'h17, 7'h18);
    `CHK("locked refuse", 1'b1, rf)
    keys(1'b1);
    `CHK("broken unlock", 1'b1, map_locked)
    keys(1'b0);
    `CHK("unlocked", 1'b0, map_locked)
    wr(5'h18, 7'h01);
    `CHK("index refuse", 1'b1, rf)
    wr(5'h17, 7'h18);
    `CHK("open write", 1'b0, rf)
    repeat (3) @(negedge ref_clk);
    `CHK("last field", 7'h18, sel_fields[167:161])
    $display("lock test done");
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (12) @(negedge ref_clk);
    sys_rst = 1'b0;
    @(negedge ref_clk);
    `CHK("fields at reset", 168'h0, sel_fields)
    `CHK("inputs at reset", 24'h00_0000, periph_in)
    t_codes();
    t_fan();
    t_lock();
    conclude();
  end
  // watchdog
  initial begin
    repeat (5000) @(posedge ref_clk);
    mismatches++;
    conclude();
  end
endmodule // testbench
